// ---- inc/timer8_defs.svh ----
`ifndef TIMER8_DEFS_SVH
`define TIMER8_DEFS_SVH

// register byte offsets on the bus
`define T8_OFF_CTRL_A 8'h00
`define T8_OFF_CTRL_B 8'h04
`define T8_OFF_COUNTER 8'h08
`define T8_OFF_COMPARE_A 8'h0C
`define T8_OFF_COMPARE_B 8'h10
`define T8_OFF_INT_MASK 8'h14
`define T8_OFF_INT_FLAG 8'h18

// control register A fields
`define T8_COM_A_LSB 6
`define T8_COM_B_LSB 4
`define T8_WGM_LOW_LSB 0
// control register B fields
`define T8_FORCE_A_BIT 7
`define T8_FORCE_B_BIT 6
`define T8_WGM_HIGH_BIT 3
`define T8_CS_LSB 0
// mask and flag bit positions
`define T8_OVF_BIT 0
`define T8_CMP_A_BIT 1
`define T8_CMP_B_BIT 2

// counter landmarks
`define T8_BOTTOM 8'h00
`define T8_MAX 8'hFF
`define T8_CS_STOPPED 3'h0
// waveform mode codes
`define T8_WGM_NORMAL 3'h0
`define T8_WGM_PHASE_FF 3'h1
`define T8_WGM_CLEAR_ON_MATCH 3'h2
`define T8_WGM_FAST_FF 3'h3
`define T8_WGM_PHASE_OCA 3'h5
`define T8_WGM_FAST_OCA 3'h7
// compare output mode codes
`define T8_COM_OFF 2'h0
`define T8_COM_TOGGLE 2'h1
`define T8_COM_CLEAR 2'h2
`define T8_COM_SET 2'h3
// bus answers
`define T8_HRESP_OKAY 1'b0
`define T8_HSIZE_WORD 3'h2

`endif

// ---- inc/timer8_pkg.sv ----
package timer8_pkg;

   // how the counting sequence treats the compare registers and outputs
   typedef enum logic [1:0] {PWM_NONE, PWM_FAST, PWM_PHASE} pwm_kind_t;

   // whole state of the timer top
   typedef struct packed {
      logic [7:0] cnt;
      logic countUp;
      logic block;
      logic [7:0] ocrA;
      logic [7:0] ocrB;
      logic [7:0] bufA;
      logic [7:0] bufB;
      logic [1:0] comA;
      logic [1:0] comB;
      logic [2:0] wgm;
      logic [2:0] cs;
      logic flagA;
      logic flagB;
      logic flagOv;
      logic maskA;
      logic maskB;
      logic maskOv;
      logic forceA;
      logic forceB;
      logic wrPend;
      logic [7:0] wrAddr;
      logic [31:0] rdata;
   } timer_state_t;

   // state of one waveform output stage
   typedef struct packed {
      logic oc;
   } wave_state_t;

endpackage

// ---- inc/wave_if.sv ----
`timescale 1ns/1ns
`default_nettype none

// carries one compare channel's events from the timer to its output stage
interface wave_if;
   logic [1:0] com;
   logic match;
   logic force_;
   logic bottomEv;
   logic countUp;
   logic toggleOk;
   timer8_pkg::pwm_kind_t kind;
   logic ocBit;
   modport ctrl (output com, match, force_, bottomEv, countUp, toggleOk, kind, input ocBit);
   modport unit (input com, match, force_, bottomEv, countUp, toggleOk, kind, output ocBit);
endinterface

`default_nettype wire

// ---- hdl/wave_unit.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "timer8_defs.svh"

module wave_unit (
   input wire logic clk_sys,
   input wire logic rst,
   wave_if.unit w
);

   timer8_pkg::wave_state_t q;
   timer8_pkg::wave_state_t d;

   // output register action per kind of mode; mode off leaves it alone
   always_comb
   begin
      d = q;
      case (w.kind)
         timer8_pkg::PWM_NONE:
         begin
            if (w.match || w.force_)
            begin
               case (w.com)
                  `T8_COM_TOGGLE: d.oc = ~q.oc;
                  `T8_COM_CLEAR: d.oc = 1'b0;
                  `T8_COM_SET: d.oc = 1'b1;
                  default: d.oc = q.oc;
               endcase
            end
         end
         timer8_pkg::PWM_FAST:
         begin
            // bottom comes after the match in time, so it wins a tie
            if (w.bottomEv && w.com == `T8_COM_CLEAR)
               d.oc = 1'b1;
            else if (w.bottomEv && w.com == `T8_COM_SET)
               d.oc = 1'b0;
            else if (w.match)
            begin
               case (w.com)
                  `T8_COM_TOGGLE: d.oc = w.toggleOk ? ~q.oc : q.oc;
                  `T8_COM_CLEAR: d.oc = 1'b0;
                  `T8_COM_SET: d.oc = 1'b1;
                  default: d.oc = q.oc;
               endcase
            end
         end
         timer8_pkg::PWM_PHASE:
         begin
            if (w.match)
            begin
               case (w.com)
                  `T8_COM_TOGGLE: d.oc = w.toggleOk ? ~q.oc : q.oc;
                  `T8_COM_CLEAR: d.oc = ~w.countUp;
                  `T8_COM_SET: d.oc = w.countUp;
                  default: d.oc = q.oc;
               endcase
            end
         end
         default: d = q;
      endcase
   end

   // mode changes never touch this register, only reset does
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         q <= '0;
      else
         q <= d;
   end

   assign w.ocBit = q.oc;

endmodule

`default_nettype wire

// ---- hdl/timer8_top.sv ----
// The implementer's own choices: the address map and the AHB-Lite register port.
`timescale 1ns/1ns
`default_nettype none
`include "timer8_defs.svh"

// How it works
// - each tick clears, increments or decrements counter
// - clock select zero stops counter, access remains
// - cpu counter write beats same-cycle count
// - waveform mode bits split across both controls
// - equality sets compare flag on next tick
// - enabled flag raises request; service or one clears
// - pwm modes buffer compares, update at top/bottom
// - cpu reaches buffer or active compare register
// - force strobe acts like match, non-pwm only
// - counter write blocks matches on next tick
// - output mode unbuffered, next match uses it
// - reset zeroes output registers, mode change keeps
// - nonzero output mode overrides port data
// - output mode zero leaves output register alone
// - output mode never alters counting sequence
// - normal mode counts up, wraps max to zero
// - normal overflow flag sets when counter hits zero
// - overflow service clears overflow flag
// - bottom is zero, top is max or compare
module timer8_top (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic tickIn,
   input wire logic ackCompA,
   input wire logic ackCompB,
   input wire logic ackOverflow,
   output logic irqCompA,
   output logic irqCompB,
   output logic irqOverflow,
   input wire logic portDataA,
   input wire logic portDataB,
   input wire logic wavePinDirectionA,
   input wire logic wavePinDirectionB,
   output logic waveOutA,
   output logic waveOutB,
   output logic waveOeNA,
   output logic waveOeNB
);

   timer8_pkg::timer_state_t q;
   timer8_pkg::timer_state_t d;

   logic tick;
   logic [7:0] top;
   timer8_pkg::pwm_kind_t kind;
   logic [8:0] step;
   logic matchA;
   logic matchB;
   logic ovfEv;
   logic bufUpdate;
   logic bottomEv;
   logic addrTaken;
   logic readReq;
   logic [7:0] wdata;

   wave_if chanA ();
   wave_if chanB ();

   // sorts a waveform mode into its family
   function automatic timer8_pkg::pwm_kind_t kindOf(input logic [2:0] m);
      case (m)
         `T8_WGM_PHASE_FF, `T8_WGM_PHASE_OCA: kindOf = timer8_pkg::PWM_PHASE;
         `T8_WGM_FAST_FF, `T8_WGM_FAST_OCA: kindOf = timer8_pkg::PWM_FAST;
         default: kindOf = timer8_pkg::PWM_NONE;
      endcase
   endfunction

   // next {direction, count} for one tick; single slope clears at top
   function automatic logic [8:0] stepCount(
      input timer8_pkg::pwm_kind_t k,
      input logic [7:0] c,
      input logic [7:0] t,
      input logic up
   );
      if (k == timer8_pkg::PWM_PHASE)
      begin
         if (up && c >= t)
            stepCount = {1'b0, 8'(c - 8'h01)};
         else if (!up && c == `T8_BOTTOM)
            stepCount = {1'b1, 8'(c + 8'h01)};
         else if (up)
            stepCount = {1'b1, 8'(c + 8'h01)};
         else
            stepCount = {1'b0, 8'(c - 8'h01)};
      end
      else if (c == t)
         stepCount = {1'b1, `T8_BOTTOM};
      else
         stepCount = {1'b1, 8'(c + 8'h01)};
   endfunction

   // read view of a register; compares show the buffer in pwm modes
   function automatic logic [7:0] regView(
      input timer8_pkg::timer_state_t s,
      input logic [7:0] a
   );
      logic pwm;
      pwm = kindOf(s.wgm) != timer8_pkg::PWM_NONE;
      case (a)
         `T8_OFF_CTRL_A: regView = {s.comA, s.comB, 2'h0, s.wgm[1:0]};
         `T8_OFF_CTRL_B: regView = {4'h0, s.wgm[2], s.cs};
         `T8_OFF_COUNTER: regView = s.cnt;
         `T8_OFF_COMPARE_A: regView = pwm ? s.bufA : s.ocrA;
         `T8_OFF_COMPARE_B: regView = pwm ? s.bufB : s.ocrB;
         `T8_OFF_INT_MASK: regView = {5'h00, s.maskB, s.maskA, s.maskOv};
         `T8_OFF_INT_FLAG: regView = {5'h00, s.flagB, s.flagA, s.flagOv};
         default: regView = 8'h00;
      endcase
   endfunction

   // timer events seen this cycle
   assign tick = tickIn && (q.cs != `T8_CS_STOPPED);
   assign kind = kindOf(q.wgm);
   assign top = (q.wgm == `T8_WGM_CLEAR_ON_MATCH || q.wgm == `T8_WGM_PHASE_OCA
      || q.wgm == `T8_WGM_FAST_OCA) ? q.ocrA : `T8_MAX;
   assign step = stepCount(kind, q.cnt, top, q.countUp);
   // a counter write blanks the comparator through the next tick
   assign matchA = tick && !q.block && q.cnt == q.ocrA;
   assign matchB = tick && !q.block && q.cnt == q.ocrB;
   assign bottomEv = tick && kind == timer8_pkg::PWM_FAST && q.cnt == top;
   assign bufUpdate = tick && ((kind == timer8_pkg::PWM_FAST && q.cnt == top)
      || (kind == timer8_pkg::PWM_PHASE && q.countUp && q.cnt >= top));

   // overflow: max to zero in non-pwm, top in fast, reaching bottom in phase
   always_comb
   begin
      case (kind)
         timer8_pkg::PWM_PHASE: ovfEv = tick && !q.countUp && q.cnt == 8'h01;
         timer8_pkg::PWM_FAST: ovfEv = tick && q.cnt == top;
         default: ovfEv = tick && q.cnt == `T8_MAX;
      endcase
   end

   // bus request decode; a read straight after a write waits one cycle so
   // that it sees the written value
   assign readReq = hsel && htrans[1] && !hwrite;
   assign hreadyout = !(q.wrPend && readReq);
   assign addrTaken = hsel && htrans[1] && hready;
   assign wdata = hwdata[7:0];
   assign hrdata = q.rdata;
   assign hresp = `T8_HRESP_OKAY;

   // next state: counting first, then cpu writes on top, flag sets last
   always_comb
   begin
      d = q;
      d.forceA = 1'b0;
      d.forceB = 1'b0;
      if (tick)
      begin
         d.block = 1'b0;
         d.cnt = step[7:0];
         d.countUp = step[8];
         if (bufUpdate)
         begin
            d.ocrA = q.bufA;
            d.ocrB = q.bufB;
         end
      end
      // interrupt service clears its flag
      if (ackCompA)
         d.flagA = 1'b0;
      if (ackCompB)
         d.flagB = 1'b0;
      if (ackOverflow)
         d.flagOv = 1'b0;
      // write data phase
      if (q.wrPend)
      begin
         case (q.wrAddr)
            `T8_OFF_CTRL_A:
            begin
               d.comA = wdata[`T8_COM_A_LSB +: 2];
               d.comB = wdata[`T8_COM_B_LSB +: 2];
               d.wgm[1:0] = wdata[`T8_WGM_LOW_LSB +: 2];
            end
            `T8_OFF_CTRL_B:
            begin
               d.wgm[2] = wdata[`T8_WGM_HIGH_BIT];
               d.cs = wdata[`T8_CS_LSB +: 3];
               // strobes only act outside pwm modes
               d.forceA = wdata[`T8_FORCE_A_BIT] && kind == timer8_pkg::PWM_NONE;
               d.forceB = wdata[`T8_FORCE_B_BIT] && kind == timer8_pkg::PWM_NONE;
            end
            `T8_OFF_COUNTER:
            begin
               d.cnt = wdata;
               d.block = 1'b1;
            end
            `T8_OFF_COMPARE_A:
            begin
               d.bufA = wdata;
               if (kind == timer8_pkg::PWM_NONE)
                  d.ocrA = wdata;
            end
            `T8_OFF_COMPARE_B:
            begin
               d.bufB = wdata;
               if (kind == timer8_pkg::PWM_NONE)
                  d.ocrB = wdata;
            end
            `T8_OFF_INT_MASK:
            begin
               d.maskOv = wdata[`T8_OVF_BIT];
               d.maskA = wdata[`T8_CMP_A_BIT];
               d.maskB = wdata[`T8_CMP_B_BIT];
            end
            `T8_OFF_INT_FLAG:
            begin
               // writing one clears
               if (wdata[`T8_OVF_BIT])
                  d.flagOv = 1'b0;
               if (wdata[`T8_CMP_A_BIT])
                  d.flagA = 1'b0;
               if (wdata[`T8_CMP_B_BIT])
                  d.flagB = 1'b0;
            end
            default: d.wrPend = 1'b0;
         endcase
      end
      // hardware sets land after every clear so no event is lost
      if (matchA)
         d.flagA = 1'b1;
      if (matchB)
         d.flagB = 1'b1;
      if (ovfEv)
         d.flagOv = 1'b1;
      // address phase: only whole-word writes are kept, reads sample now
      d.wrPend = addrTaken && hwrite && hsize == `T8_HSIZE_WORD;
      d.wrAddr = haddr[7:0];
      if (addrTaken && !hwrite)
         d.rdata = {24'h000000, regView(q, haddr[7:0])};
   end

   // every register on the one clock, synchronous reset
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         q <= '0;
      else
         q <= d;
   end

   // interrupt requests gated by their enables
   assign irqCompA = q.flagA && q.maskA;
   assign irqCompB = q.flagB && q.maskB;
   assign irqOverflow = q.flagOv && q.maskOv;

   // compare channel events toward the output stages
   assign chanA.com = q.comA;
   assign chanA.match = matchA;
   assign chanA.force_ = q.forceA;
   assign chanA.bottomEv = bottomEv;
   assign chanA.countUp = q.countUp;
   assign chanA.toggleOk = q.wgm[2];
   assign chanA.kind = kind;
   assign chanB.com = q.comB;
   assign chanB.match = matchB;
   assign chanB.force_ = q.forceB;
   assign chanB.bottomEv = bottomEv;
   assign chanB.countUp = q.countUp;
   assign chanB.toggleOk = 1'b0; // channel b has no pwm toggle
   assign chanB.kind = kind;

   wave_unit waveA (
      .clk_sys(clk_sys),
      .rst(rst),
      .w(chanA.unit)
   );

   wave_unit waveB (
      .clk_sys(clk_sys),
      .rst(rst),
      .w(chanB.unit)
   );

   // pin override is mode independent; direction stays with the port
   assign waveOutA = (q.comA != `T8_COM_OFF) ? chanA.ocBit : portDataA;
   assign waveOutB = (q.comB != `T8_COM_OFF) ? chanB.ocBit : portDataB;
   assign waveOeNA = !wavePinDirectionA;
   assign waveOeNB = !wavePinDirectionB;

endmodule

`default_nettype wire

// ---- dv/timer8_top_props.sv ----
`timescale 1ns/1ns
`default_nettype none

module timer8_top_props (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hresp,
   input wire logic tickIn,
   input wire logic ackCompA,
   input wire logic ackOverflow,
   input wire logic irqCompA,
   input wire logic irqOverflow,
   input wire logic portDataA,
   input wire logic wavePinDirectionA,
   input wire logic waveOutA,
   input wire logic waveOeNA
);
   logic wrD_q;
   logic anyWr_q;

   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);

   // write data phase marker; registers change at the edge ending it
   always_ff @(posedge clk_sys)
   begin
      wrD_q <= !rst && hsel && htrans[1] && hready && hwrite;
      anyWr_q <= !rst && (anyWr_q || (hsel && htrans[1] && hready && hwrite));
   end

   sequence s_ackA;
      ackCompA && !tickIn;
   endsequence
   sequence s_ackOv;
      ackOverflow && !tickIn;
   endsequence
   // force acts one edge after the data phase, so a pin may move two edges on
   sequence s_waveCause;
      $changed(portDataA) || $past(tickIn) || $past(wrD_q) || $past(wrD_q, 2)
         || $past(wrD_q, 3);
   endsequence

   a_oe_dir_a: assert property (waveOeNA == !wavePinDirectionA)
      else $error("pin enable A does not follow direction");
   a_port_idle: assert property (!anyWr_q |-> waveOutA == portDataA)
      else $error("pin A not port data before any write");
   a_ack_clr_a: assert property (s_ackA |=> !irqCompA)
      else $error("service did not clear compare A request");
   a_ack_clr_ov: assert property (s_ackOv |=> !irqOverflow)
      else $error("service did not clear overflow request");
   a_irq_cause: assert property ($rose(irqCompA) |-> $past(tickIn) || $past(wrD_q))
      else $error("compare A request rose without a tick");
   a_wave_cause: assert property ($changed(waveOutA) |-> s_waveCause)
      else $error("pin A moved without any event");
   a_ov_hold: assert property (irqOverflow && !ackOverflow && !wrD_q |=> irqOverflow)
      else $error("overflow request dropped by itself");
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("bus response not okay");
endmodule

bind timer8_top timer8_top_props chk_u (
   .clk_sys(clk_sys), .rst(rst), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
   .hready(hready), .hresp(hresp), .tickIn(tickIn), .ackCompA(ackCompA),
   .ackOverflow(ackOverflow), .irqCompA(irqCompA), .irqOverflow(irqOverflow),
   .portDataA(portDataA), .wavePinDirectionA(wavePinDirectionA),
   .waveOutA(waveOutA), .waveOeNA(waveOeNA)
);

`default_nettype wire

// ---- dv/pin_load.sv ----
`timescale 1ns/1ns
`default_nettype none

module pin_load (
   input wire logic waveOut,
   input wire logic waveOeN,
   output logic pad
);
   // an external pull-up holds the line while the pin is an input
   assign pad = waveOeN ? 1'b1 : waveOut;
endmodule

`default_nettype wire

// ---- dv/eight_bit_timer_compare_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "timer8_defs.svh"

// counts every comparison and reports a mismatch at once
`define CHK(a, e) \
   begin \
      cmpCount++; \
      if ((a) !== (e)) \
      begin \
         errCount++; \
         $display("FAIL t=%0t got=%0h exp=%0h", $time, (a), (e)); \
      end \
   end

module eight_bit_timer_compare_tb;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h00000000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h00000000;
   logic hready;
   logic [31:0] hrdata;
   logic hresp;
   logic tickIn = 1'b0;
   logic ackCompA = 1'b0;
   logic ackOverflow = 1'b0;
   logic irqCompA;
   logic irqCompB;
   logic irqOverflow;
   logic portDataA = 1'b1;
   logic dirA = 1'b0;
   logic waveOutA;
   logic waveOutB;
   logic oeNA;
   logic oeNB;
   logic padA;
   logic padB;
   int errCount = 0;
   int cmpCount = 0;

   always #5 clk_sys = ~clk_sys;

   timer8_top dut_u (
      .clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
      .hreadyout(hready), .hrdata(hrdata), .hresp(hresp), .tickIn(tickIn),
      .ackCompA(ackCompA), .ackCompB(1'b0), .ackOverflow(ackOverflow),
      .irqCompA(irqCompA), .irqCompB(irqCompB), .irqOverflow(irqOverflow),
      .portDataA(portDataA), .portDataB(1'b0), .wavePinDirectionA(dirA),
      .wavePinDirectionB(1'b1), .waveOutA(waveOutA), .waveOutB(waveOutB),
      .waveOeNA(oeNA), .waveOeNB(oeNB)
   );
   pin_load padA_u (.waveOut(waveOutA), .waveOeN(oeNA), .pad(padA));
   pin_load padB_u (.waveOut(waveOutB), .waveOeN(oeNB), .pad(padB));

   // one single word transfer; read data is taken at the edge ending the data phase
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
      output logic [31:0] r);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge clk_sys); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= {24'h000000, d};
      do @(posedge clk_sys); while (hready !== 1'b1);
      r = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      xfer(1'b1, a, d, r);
   endtask

   task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
      logic [31:0] r;
      xfer(1'b0, a, 8'h00, r);
      `CHK(r, {24'h000000, e})
   endtask

   // back-to-back ticks, ends just after the last ticking edge
   task automatic tick(input int n);
      tickIn <= 1'b1;
      repeat (n) @(posedge clk_sys);
      tickIn <= 1'b0;
   endtask

   task automatic tReset;
      #1;
      `CHK(padA, 1'b1)
      `CHK(padB, 1'b0)
      rdChk(8'h1C, 8'h00);
      $display("tReset done");
   endtask

   task automatic tStop;
      wr(`T8_OFF_COUNTER, 8'h5A);
      tick(4);
      rdChk(`T8_OFF_COUNTER, 8'h5A);
      wr(`T8_OFF_CTRL_B, 8'h01);
      // ticks surround the write, whose own edge must take the written value
      fork
         tick(3);
         wr(`T8_OFF_COUNTER, 8'h80);
      join
      rdChk(`T8_OFF_COUNTER, 8'h81);
      $display("tStop done");
   endtask

   task automatic tWrap;
      wr(`T8_OFF_INT_FLAG, 8'h07);
      wr(`T8_OFF_INT_MASK, 8'h01);
      // start value kept off both compares so no match is lost to blocking
      wr(`T8_OFF_COUNTER, 8'hFE);
      tick(1);
      #1;
      `CHK(irqOverflow, 1'b0)
      tick(1);
      #1;
      `CHK(irqOverflow, 1'b1)
      rdChk(`T8_OFF_COUNTER, 8'h00);
      ackOverflow <= 1'b1;
      @(posedge clk_sys);
      ackOverflow <= 1'b0;
      #1;
      `CHK(irqOverflow, 1'b0)
      $display("tWrap done");
   endtask

   task automatic tMatch;
      wr(`T8_OFF_COMPARE_A, 8'h10);
      wr(`T8_OFF_INT_MASK, 8'h02);
      wr(`T8_OFF_COUNTER, 8'h10);
      tick(1);
      #1;
      `CHK(irqCompA, 1'b0)
      wr(`T8_OFF_COUNTER, 8'h0F);
      tick(2);
      #1;
      `CHK(irqCompA, 1'b1)
      rdChk(`T8_OFF_INT_FLAG, 8'h02);
      ackCompA <= 1'b1;
      @(posedge clk_sys);
      ackCompA <= 1'b0;
      #1;
      `CHK(irqCompA, 1'b0)
      $display("tMatch done");
   endtask

   task automatic tForce;
      dirA <= 1'b1;
      wr(`T8_OFF_CTRL_B, 8'h00);
      wr(`T8_OFF_CTRL_A, 8'hC0);
      #1;
      `CHK(padA, 1'b0)
      wr(`T8_OFF_CTRL_B, 8'h80);
      @(posedge clk_sys);
      #1;
      `CHK(padA, 1'b1)
      rdChk(`T8_OFF_INT_FLAG, 8'h00);
      rdChk(`T8_OFF_COUNTER, 8'h11);
      wr(`T8_OFF_CTRL_A, 8'h40);
      #1;
      `CHK(padA, 1'b1)
      wr(`T8_OFF_CTRL_B, 8'h80);
      @(posedge clk_sys);
      #1;
      `CHK(padA, 1'b0)
      wr(`T8_OFF_CTRL_A, 8'h00);
      #1;
      `CHK(padA, portDataA)
      wr(`T8_OFF_CTRL_B, 8'h80);
      wr(`T8_OFF_CTRL_A, 8'h40);
      #1;
      `CHK(padA, 1'b0)
      $display("tForce done");
   endtask

   task automatic tBuffer;
      wr(`T8_OFF_CTRL_A, 8'h03);
      wr(`T8_OFF_CTRL_B, 8'h01);
      wr(`T8_OFF_COMPARE_A, 8'h30);
      rdChk(`T8_OFF_COMPARE_A, 8'h30);
      wr(`T8_OFF_COUNTER, 8'h0F);
      tick(2);
      rdChk(`T8_OFF_INT_FLAG, 8'h02);
      wr(`T8_OFF_INT_FLAG, 8'h07);
      wr(`T8_OFF_COUNTER, 8'hFE);
      tick(3);
      rdChk(`T8_OFF_INT_FLAG, 8'h05);
      wr(`T8_OFF_INT_FLAG, 8'h07);
      wr(`T8_OFF_COUNTER, 8'h2F);
      tick(2);
      rdChk(`T8_OFF_INT_FLAG, 8'h02);
      $display("tBuffer done");
   endtask

   // clear on match: top is compare a, count restarts from bottom
   task automatic tCtc;
      wr(`T8_OFF_CTRL_A, 8'h02);
      wr(`T8_OFF_COMPARE_A, 8'h05);
      rdChk(`T8_OFF_COMPARE_A, 8'h05);
      wr(`T8_OFF_INT_FLAG, 8'h07);
      wr(`T8_OFF_COUNTER, 8'h03);
      tick(4);
      rdChk(`T8_OFF_COUNTER, 8'h01);
      rdChk(`T8_OFF_INT_FLAG, 8'h06);
      $display("tCtc done");
   endtask

   task automatic endOfTest;
      $display("comparisons %0d mismatches %0d", cmpCount, errCount);
      if (errCount == 0 && cmpCount > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // the tests need about 120 cycles; a hang counts as a mismatch
   initial
   begin
      #100000;
      errCount++;
      endOfTest;
   end

   initial
   begin
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      tReset;
      tStop;
      tWrap;
      tMatch;
      tForce;
      tBuffer;
      tCtc;
      endOfTest;
   end
endmodule

`default_nettype wire
